// *** regional_clock_divider_consts.svh ***
// Offsets, field positions, reset values and timing counts of the regional clock divider
`ifndef REGIONAL_CLOCK_DIVIDER_CONSTS_SVH
`define REGIONAL_CLOCK_DIVIDER_CONSTS_SVH

`define RCD_CTRL_OFFSET 4'h0
`define RCD_STATUS_OFFSET 4'h4
`define RCD_DIV_LSB 0
`define RCD_DIV_MSB 3
`define RCD_DIV_BYPASS 4'h0
`define RCD_DIV_MIN 4'h1
`define RCD_DIV_MAX 4'h8
`define RCD_CTRL_RESET 32'h0000_0000
`define RCD_ST_RUN 0
`define RCD_ST_GSR 1
`define RCD_ST_CLR 2
`define RCD_ST_COUNT_LSB 4
`define RCD_ST_MODE_LSB 8
`define RCD_GATE_LATENCY 4
`define RCD_SYNC_STAGES 3

`endif

// *** regional_clock_divider_pkg.sv ***
// Types of the regional clock divider
package regional_clock_divider_pkg;
  typedef enum logic [1:0] {
    MODE_BYPASS = 2'b00,
    MODE_DIV_ONE = 2'b01,
    MODE_DIV_N = 2'b10
  } mode_type;
endpackage

// *** sync_delay.sv ***
// Input synchroniser and delay line with optional asynchronous set
`timescale 1ns/100ps
module sync_delay #(
  parameter int DEPTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous set, tie low when unused
  input wire logic async_set,
  // Data
  input wire logic d,
  output logic q
);
  logic [DEPTH-1:0] stage_q;

  // Set acts at once so a held condition shows without delay; release walks the chain
  always_ff @(posedge clk or posedge async_set) begin
    if (async_set) begin
      stage_q <= '1;
    end else if (rst) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[DEPTH-2:0], d};
    end
  end

  assign q = stage_q[DEPTH-1];
endmodule // sync_delay

// *** regional_clock_divider.sv ***
// Regional clock buffer with integer divider, gate enable, clear and Avalon-MM control
// Operation
// - Divide setting 1 to 8 gives output at input frequency divided by setting.
// - Unconfigured divide setting means passthrough: input clock forwarded undivided.
// - Outside passthrough, output starts or stops toggling four input cycles after gate enable changes.
// - Divider clear asynchronously resets the count and, outside passthrough, holds the output low.
// - Outside passthrough, output stays static while global set/reset is high, even with enable high.
// - Output toggles four input cycles after global set/reset falls, enable high.
// - Odd divide above one: low phase is one input cycle longer than high phase.
// - All divide values share one phase alignment; passthrough may differ.
// - After clear release, toggling resumes from a freshly reset divide count.
`timescale 1ns/100ps
`include "regional_clock_divider_consts.svh"
module regional_clock_divider (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // Control pins
  input wire logic CLK_GATE_EN,
  input wire logic DIVIDER_CLEAR,
  input wire logic GLOBAL_SET_RESET,
  // Clock outputs
  output logic CLK_OUT,
  output logic DIV_LEVEL,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  logic [3:0] div_q;
  logic [3:0] div_d;
  logic [2:0] count_q;
  logic [2:0] count_d;
  logic level_q;
  logic level_d;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic ce_q;
  logic gsr_q;
  logic clr_q;
  regional_clock_divider_pkg::mode_type mode;

  // High-phase length; divide by one keeps the level high and lets the clock through
  function automatic logic [3:0] half_of(input logic [3:0] div);
    half_of = (div == `RCD_DIV_MIN) ? `RCD_DIV_MIN : {1'b0, div[3:1]};
  endfunction

  function automatic regional_clock_divider_pkg::mode_type mode_of(input logic [3:0] div);
    if (div == `RCD_DIV_MIN) begin
      mode_of = regional_clock_divider_pkg::MODE_DIV_ONE;
    end else if (div > `RCD_DIV_MIN && div <= `RCD_DIV_MAX) begin
      mode_of = regional_clock_divider_pkg::MODE_DIV_N;
    end else begin
      mode_of = regional_clock_divider_pkg::MODE_BYPASS;
    end
  endfunction

  // Pin synchronisers; enable and every release take three cycles, and the level flop adds the fourth cycle of the gate latency
  sync_delay #(.DEPTH(`RCD_SYNC_STAGES)) u_ce_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .async_set(1'b0),
    .d(CLK_GATE_EN),
    .q(ce_q)
  );
  sync_delay #(.DEPTH(`RCD_SYNC_STAGES)) u_gsr_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .async_set(GLOBAL_SET_RESET),
    .d(GLOBAL_SET_RESET),
    .q(gsr_q)
  );
  sync_delay #(.DEPTH(`RCD_SYNC_STAGES)) u_clr_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .async_set(DIVIDER_CLEAR),
    .d(DIVIDER_CLEAR),
    .q(clr_q)
  );

  // Divider control; passthrough ignores enable and clear
  wire run_d = ce_q & ~gsr_q & ~clr_q & (mode != regional_clock_divider_pkg::MODE_BYPASS);
  wire [2:0] last_count = 3'(div_q - `RCD_DIV_MIN);
  assign mode = mode_of(div_q);

  always_comb begin
    count_d = 3'h0;
    level_d = 1'b0;
    if (run_d) begin
      count_d = (count_q == last_count) ? 3'h0 : 3'(count_q + 3'h1);
      level_d = {1'b0, count_q} < half_of(div_q);
    end
  end

  // Clear is asynchronous so the output drops without waiting for a clock
  always_ff @(posedge CLK_SYS or posedge DIVIDER_CLEAR) begin
    if (DIVIDER_CLEAR) begin
      count_q <= 3'h0;
      level_q <= 1'b0;
    end else if (SYS_RST) begin
      count_q <= 3'h0;
      level_q <= 1'b0;
    end else begin
      count_q <= count_d;
      level_q <= level_d;
    end
  end

  // Gated level; divide by one ANDs the input clock with a flop level, so its first and last pulse may be short
  wire level_gated = level_q & ~gsr_q & ~clr_q;
  always_comb begin
    case (mode)
      regional_clock_divider_pkg::MODE_BYPASS: CLK_OUT = CLK_SYS;
      regional_clock_divider_pkg::MODE_DIV_ONE: CLK_OUT = CLK_SYS & level_gated;
      regional_clock_divider_pkg::MODE_DIV_N: CLK_OUT = level_gated;
      default: CLK_OUT = 1'b0;
    endcase
  end
  assign DIV_LEVEL = level_q;

  // Avalon slave: one wait state; read data is registered as acknowledge rises, write lands at the acknowledge edge
  wire req = (AVS_READ | AVS_WRITE) & ~ack_q;
  wire sel_ctrl = AVS_ADDRESS == `RCD_CTRL_OFFSET;
  wire sel_status = AVS_ADDRESS == `RCD_STATUS_OFFSET;
  wire do_write = AVS_WRITE & ack_q & sel_ctrl & AVS_BYTEENABLE[0];
  assign div_d = do_write ? AVS_WRITEDATA[`RCD_DIV_MSB:`RCD_DIV_LSB] : div_q;
  assign AVS_WAITREQUEST = ~ack_q;
  assign AVS_READDATA = rdata_q;

  always_comb begin
    rdata_d = rdata_q;
    if (req & AVS_READ) begin
      rdata_d = 32'h0000_0000;
      if (sel_ctrl) begin
        rdata_d[`RCD_DIV_MSB:`RCD_DIV_LSB] = div_q;
      end else if (sel_status) begin
        rdata_d[`RCD_ST_RUN] = level_gated | (count_q != 3'h0);
        rdata_d[`RCD_ST_GSR] = gsr_q;
        rdata_d[`RCD_ST_CLR] = clr_q;
        rdata_d[`RCD_ST_COUNT_LSB +: 3] = count_q;
        rdata_d[`RCD_ST_MODE_LSB +: 2] = mode;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      div_q <= 4'(`RCD_CTRL_RESET);
    end else begin
      ack_q <= req;
      rdata_q <= rdata_d;
      div_q <= div_d;
    end
  end

  // Checks
  a_gate_start:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      $rose(level_q) |-> $past(CLK_GATE_EN, `RCD_GATE_LATENCY))
    else $error("output started without enable four cycles earlier");
  a_gate_stop:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      (!CLK_GATE_EN && !DIVIDER_CLEAR) [*4] |=> !level_q)
    else $error("output still toggling four cycles after enable low");
  a_clear_low:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      DIVIDER_CLEAR |-> !level_q && count_q == 3'h0)
    else $error("clear did not hold divider low");
  a_gsr_static:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      GLOBAL_SET_RESET |=> !level_q)
    else $error("output toggled during global set reset");
  a_gsr_release:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      $rose(level_q) |-> !$past(GLOBAL_SET_RESET, 1) && !$past(GLOBAL_SET_RESET, 2)
        && !$past(GLOBAL_SET_RESET, 3) && !$past(GLOBAL_SET_RESET, 4))
    else $error("output started too soon after global set reset");
  a_phase_align:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      $rose(level_q) |-> $past(count_q) == 3'h0)
    else $error("high phase not aligned to count zero");
  a_fresh_count:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      $fell(clr_q) |-> count_q == 3'h0)
    else $error("count not fresh after clear release");
  a_count_wrap:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST || DIVIDER_CLEAR)
      run_d && count_q == last_count |=> count_q == 3'h0)
    else $error("divide count did not wrap at setting");
  a_high_phase:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST || DIVIDER_CLEAR)
      run_d && mode == regional_clock_divider_pkg::MODE_DIV_N && {1'b0, count_q} < {1'b0, div_q[3:1]} |=> level_q)
    else $error("high phase too short");
  a_low_phase:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST || DIVIDER_CLEAR)
      run_d && mode == regional_clock_divider_pkg::MODE_DIV_N && {1'b0, count_q} >= {1'b0, div_q[3:1]} |=> !level_q)
    else $error("low phase too short");
  a_div_one_high:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST || DIVIDER_CLEAR)
      run_d && mode == regional_clock_divider_pkg::MODE_DIV_ONE |=> level_q)
    else $error("divide by one level not held high");
  a_clear_output:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      DIVIDER_CLEAR && mode != regional_clock_divider_pkg::MODE_BYPASS |-> !CLK_OUT)
    else $error("clock output not low during clear");
  a_gsr_output:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      GLOBAL_SET_RESET && mode != regional_clock_divider_pkg::MODE_BYPASS |-> !CLK_OUT)
    else $error("clock output not static during global set reset");
  a_bus_one_wait:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
endmodule // regional_clock_divider

// *** pin_source.sv ***
// Partner model driving gate enable, clear and global set/reset pins
`timescale 1ns/100ps
module pin_source (
  // Clock
  input wire logic clk,
  // Requests
  input wire logic byp,
  input wire logic w_en,
  input wire logic w_clr,
  input wire logic w_gsr,
  // Pins
  output logic en = 1'b0,
  output logic clr = 1'b0,
  output logic global_set_reset = 1'b0
);
  // Enable and clear do nothing in passthrough, so they stay low there
  always @(posedge clk) begin
    en <= w_en & ~byp;
    clr <= w_clr & ~byp;
    global_set_reset <= w_gsr;
  end
endmodule // pin_source

// *** testbench.sv ***
// Self-checking testbench of the regional clock divider
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rdn = 1'b0;
  logic wrn = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] be = 4'hf;
  logic byp = 1'b1;
  logic w_en = 1'b0;
  logic w_clr = 1'b0;
  logic w_gsr = 1'b0;
  logic [31:0] rdat, rd, rnd;
  logic wreq, cko, lvl, en, clr, global_set_reset;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int n, e, h;
  int divs[$] = '{2, 3, 4, 5, 6, 7, 8};
  pin_source i_pins (.clk(clk), .byp(byp), .w_en(w_en), .w_clr(w_clr), .w_gsr(w_gsr),
    .en(en), .clr(clr), .global_set_reset(global_set_reset));
  regional_clock_divider i_dut (.CLK_SYS(clk), .SYS_RST(rst), .CLK_GATE_EN(en), .DIVIDER_CLEAR(clr),
    .GLOBAL_SET_RESET(global_set_reset), .CLK_OUT(cko), .DIV_LEVEL(lvl), .AVS_ADDRESS(adr), .AVS_READ(rdn),
    .AVS_WRITE(wrn), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic test_done();
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Request held until waitrequest is sampled low at a rising edge; read data taken at that edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b,
      output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wd <= d;
    be <= b;
    wrn <= w;
    rdn <= ~w;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    q = rdat;
    wrn <= 1'b0;
    rdn <= 1'b0;
  endtask
  // Edges from a pin change to the first high level
  task automatic rise(output int k);
    k = 0;
    while (k < 20) begin
      @(negedge clk);
      if (lvl === 1'b1) break;
      @(posedge clk);
      k++;
    end
  endtask
  // Length of the current phase at level v
  task automatic run(input logic v, output int k);
    k = 1;
    while (k < 20) begin
      @(negedge clk);
      if (lvl !== v) break;
      k++;
    end
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 4000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    void'($urandom(29));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0000_0000, 4'hf, rd);
    check(rd, 32'h0000_0000);
    @(negedge clk);
    #25 check(32'(cko), 32'h0000_0000);
    #50 check(32'(cko), 32'h0000_0001);
    rnd = $urandom;
    bus(1'b1, 4'h8, rnd, 4'hf, rd);
    bus(1'b1, 4'h4, rnd, 4'hf, rd);
    bus(1'b1, 4'h0, rnd | 32'h0000_0001, 4'he, rd);
    bus(1'b0, 4'h8, 32'h0000_0000, 4'hf, rd);
    check(rd, 32'h0000_0000);
    bus(1'b0, 4'h0, 32'h0000_0000, 4'hf, rd);
    check(32'(rd[3:0]), 32'h0000_0000);
    // Out-of-range setting falls back to passthrough
    bus(1'b1, 4'h0, 32'h0000_0009, 4'hf, rd);
    bus(1'b0, 4'h4, 32'h0000_0000, 4'hf, rd);
    check(rd, 32'h0000_0000);
    @(negedge clk);
    #25 check(32'(cko), 32'h0000_0000);
    #50 check(32'(cko), 32'h0000_0001);
    // Divide by one: level held high, output follows the input clock
    bus(1'b1, 4'h0, 32'h0000_0001, 4'hf, rd);
    @(posedge clk);
    byp <= 1'b0;
    w_en <= 1'b1;
    @(posedge clk);
    rise(e);
    check(32'(e), 32'h0000_0004);
    #25 check(32'(cko), 32'h0000_0000);
    #50 check(32'(cko), 32'h0000_0001);
    run(1'b1, h);
    check(32'(h), 32'h0000_0014);
    // Setting changes only under clear, so every start is from a fresh count
    while (divs.size() > 0) begin
      h = $urandom % divs.size();
      n = divs[h];
      divs.delete(h);
      @(posedge clk);
      w_clr <= 1'b1;
      @(posedge clk);
      #25 check(32'({lvl, cko}), 32'h0000_0000);
      bus(1'b1, 4'h0, 32'(n), 4'hf, rd);
      bus(1'b0, 4'h0, 32'h0000_0000, 4'hf, rd);
      check(32'(rd[3:0]), 32'(n));
      bus(1'b0, 4'h4, 32'h0000_0000, 4'hf, rd);
      check(rd, 32'h0000_0204);
      run(1'b0, e);
      check(32'(e), 32'h0000_0014);
      @(posedge clk);
      w_clr <= 1'b0;
      @(posedge clk);
      rise(e);
      check(32'(e), 32'h0000_0004);
      run(1'b1, h);
      run(1'b0, e);
      check(32'(h), 32'(n / 2));
      check(32'(e), 32'(n - n / 2));
    end
    @(posedge clk);
    w_en <= 1'b0;
    repeat (6) @(posedge clk);
    run(1'b0, e);
    check(32'(e), 32'h0000_0014);
    @(posedge clk);
    w_en <= 1'b1;
    @(posedge clk);
    rise(e);
    check(32'(e), 32'h0000_0004);
    @(posedge clk);
    w_gsr <= 1'b1;
    @(posedge clk);
    #25 check(32'(cko), 32'h0000_0000);
    bus(1'b0, 4'h4, 32'h0000_0000, 4'hf, rd);
    check(rd, 32'h0000_0202);
    @(posedge clk);
    run(1'b0, e);
    check(32'(e), 32'h0000_0014);
    @(posedge clk);
    w_gsr <= 1'b0;
    @(posedge clk);
    rise(e);
    check(32'(e), 32'h0000_0004);
    test_done();
  end
endmodule // testbench
